// file: rtl/mcu_port_io_block.sv
// parallel i/o ports: direction, pull-up, open-drain and data registers
//
// Operation
// [R01] direction bit 0 input, 1 output
// [R02] pin 1.1 direction bit always reads 1
// [R03] pin 1.1 pull-up bit reads 1, inert; here the bit is held at 1 but the write-only register reads 0
// [R04] pull-up bit 1 enables pull-up, write-only
// [R05] open-drain bit selects pin 1.0 drive style
// [R06] open drain sinks low, releases high
// [R07] software sets pin 1.0 output for open-drain
// [R08] open-drain register written with whole bytes
// [R09] disabling open drain restores direction behaviour
// [R10] data read returns live pin levels
// [R11] byte or bit write updates output latch; here latch bit 2.5 ignores writes, so pin 2.5 can only drive 0
// [R12] external reset option forces pin 1.1 read 1
// [R13] direction bits support single-bit set/clear
// [R14] input mode disables driver, latch retained
// [R15] unimplemented bits ignore writes, read 0
`timescale 1ns/1ps
module mcu_port_io_block (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // cpu data-memory access
    input  wire logic [7:0] cpu_addr,
    input  wire logic [7:0] cpu_wdata,
    input  wire logic       cpu_wr,
    input  wire logic       cpu_bit_set,
    input  wire logic       cpu_bit_clr,
    input  wire logic [2:0] cpu_bit_sel,
    input  wire logic       cpu_rd,
    output logic      [7:0] cpu_rdata,
    // configuration option: pin 1.1 used as external reset
    input  wire logic       ext_reset_en,
    // port 0
    input  wire logic [7:0] port0_in,
    output logic      [7:0] port0_out,
    output logic      [7:0] port0_oe,
    output logic      [7:0] port0_pu,
    // port 1
    input  wire logic [7:0] port1_in,
    output logic      [7:0] port1_out,
    output logic      [7:0] port1_oe,
    output logic      [7:0] port1_pu,
    // port 2
    input  wire logic [7:0] port2_in,
    output logic      [7:0] port2_out,
    output logic      [7:0] port2_oe,
    output logic      [7:0] port2_pu,
    // port 5
    input  wire logic [7:0] port5_in,
    output logic      [7:0] port5_out,
    output logic      [7:0] port5_oe,
    output logic      [7:0] port5_pu
);

    // ------------------------------------------------------------------
    // internal arrays, index 0..3 = port0, port1, port2, port5
    // ------------------------------------------------------------------
    logic [3:0][7:0] pin_level;
    logic [3:0][7:0] pin_direction_bits;
    logic [3:0][7:0] latch_value;
    logic [3:0][7:0] pullup_value;
    logic [3:0][7:0] out_w;
    logic [3:0][7:0] oe_w;
    logic [3:0][7:0] pu_w;
    logic [3:0]      dir_sel;
    logic [3:0]      data_sel;
    logic [3:0]      pu_sel;
    logic            od_sel;
    logic [7:0]      port1_open_drain_ctl;
    logic            pin10_open_drain_enable;
    logic [7:0]      rdata_q;
    logic [7:0]      rdata_d;
    logic [7:0]      read_value;
    logic            hit;

    // pins are taken as synchronous to mclk
    assign pin_level[0] = port0_in;
    assign pin_level[1] = port1_in;
    assign pin_level[2] = port2_in;
    assign pin_level[3] = port5_in;

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------

    // one select per register; unmapped addresses select nothing
    always_comb begin
        for (int p = 0; p < port_io_pkg::NUM_PORTS; p++) begin
            dir_sel[p]  = (cpu_addr == port_io_pkg::DIR_ADDR[p]);
            data_sel[p] = (cpu_addr == port_io_pkg::DATA_ADDR[p]);
            pu_sel[p]   = (cpu_addr == port_io_pkg::PU_ADDR[p]);
        end
        od_sel = (cpu_addr == port_io_pkg::OD_ADDR);
    end

    // ------------------------------------------------------------------
    // per-port control registers
    // ------------------------------------------------------------------

    // each port gets a direction, a data latch and a pull-up register
    for (genvar p = 0; p < port_io_pkg::NUM_PORTS; p++) begin : g_port
        // [R01] [R02] [R13] [R15] direction with bit ops and fixed ones
        port_reg #(
            .IMPL (port_io_pkg::DIR_MASK[p]),
            .ONES (port_io_pkg::DIR_ONES[p])
        ) u_dir (
            .mclk    (mclk),
            .rst_n   (rst_n),
            .sel     (dir_sel[p]),
            .wr      (cpu_wr),
            .bset    (cpu_bit_set),
            .bclr    (cpu_bit_clr),
            .bit_sel (cpu_bit_sel),
            .wdata   (cpu_wdata),
            .value   (pin_direction_bits[p])
        );

        // [R11] [R15] output latch, byte and bit writes
        port_reg #(
            .IMPL (port_io_pkg::LATCH_MASK[p]),
            .ONES (8'h00)
        ) u_latch (
            .mclk    (mclk),
            .rst_n   (rst_n),
            .sel     (data_sel[p]),
            .wr      (cpu_wr),
            .bset    (cpu_bit_set),
            .bclr    (cpu_bit_clr),
            .bit_sel (cpu_bit_sel),
            .wdata   (cpu_wdata),
            .value   (latch_value[p])
        );

        // [R03] [R04] [R15] write-only pull-up enables
        port_reg #(
            .IMPL (port_io_pkg::PU_MASK[p]),
            .ONES (port_io_pkg::PU_ONES[p])
        ) u_pullup (
            .mclk    (mclk),
            .rst_n   (rst_n),
            .sel     (pu_sel[p]),
            .wr      (cpu_wr),
            .bset    (cpu_bit_set),
            .bclr    (cpu_bit_clr),
            .bit_sel (cpu_bit_sel),
            .wdata   (cpu_wdata),
            .value   (pullup_value[p])
        );
    end

    // ------------------------------------------------------------------
    // open-drain control
    // ------------------------------------------------------------------

    // [R05] [R08] write-only; bit ops still land on the stored copy,
    // since hardware cannot stop software using them
    port_reg #(
        .IMPL (port_io_pkg::OD_MASK),
        .ONES (port_io_pkg::OD_ONES)
    ) u_open_drain (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .sel     (od_sel),
        .wr      (cpu_wr),
        .bset    (cpu_bit_set),
        .bclr    (cpu_bit_clr),
        .bit_sel (cpu_bit_sel),
        .wdata   (cpu_wdata),
        .value   (port1_open_drain_ctl)
    );

    assign pin10_open_drain_enable =
        port1_open_drain_ctl[port_io_pkg::OD_BIT];

    // ------------------------------------------------------------------
    // pad drivers
    // ------------------------------------------------------------------

    // one registered driver per bit; absent pins stay undriven.
    // open drain only matters with the pin in output mode; if software
    // forgets to set the direction the pin simply stays an input
    for (genvar p = 0; p < port_io_pkg::NUM_PORTS; p++) begin : g_pad
        for (genvar b = 0; b < port_io_pkg::PORT_W; b++) begin : g_bit
            // [R01] [R05] [R06] [R09] [R14] drive from dir, latch, mode
            pin_driver u_pin (
                .mclk       (mclk),
                .rst_n      (rst_n),
                .exists     (port_io_pkg::PIN_MASK[p][b]),
                .input_only (port_io_pkg::INPUT_ONLY[p][b]),
                .dir        (pin_direction_bits[p][b]),
                .latch      (latch_value[p][b]),
                .pu_en      (pullup_value[p][b]),
                .od_en      (port_io_pkg::OD_CAPABLE[p][b]
                             && pin10_open_drain_enable),
                .out_q      (out_w[p][b]),
                .oe_q       (oe_w[p][b]),
                .pu_q       (pu_w[p][b])
            );
        end
    end

    // driver flops feed the pads directly
    assign port0_out = out_w[0];
    assign port0_oe  = oe_w[0];
    assign port0_pu  = pu_w[0];
    assign port1_out = out_w[1];
    assign port1_oe  = oe_w[1];
    assign port1_pu  = pu_w[1];
    assign port2_out = out_w[2];
    assign port2_oe  = oe_w[2];
    assign port2_pu  = pu_w[2];
    assign port5_out = out_w[3];
    assign port5_oe  = oe_w[3];
    assign port5_pu  = pu_w[3];

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------

    // pull-up and open-drain registers are write-only and read as
    // the unmapped value; data reads show the pads, not the latch
    always_comb begin
        read_value = port_io_pkg::UNMAPPED_VAL;
        hit        = 1'b0;
        for (int p = 0; p < port_io_pkg::NUM_PORTS; p++) begin
            if (dir_sel[p]) begin
                // [R02] [R15] fixed ones shown, absent bits zero
                read_value = pin_direction_bits[p];
                hit        = 1'b1;
            end
            if (data_sel[p]) begin
                // [R10] live pin level of present pins
                read_value = pin_level[p] & port_io_pkg::PIN_MASK[p];
                hit        = 1'b1;
                // [R12] reset pin reads high under the option
                if (p == port_io_pkg::EXTRST_PORT && ext_reset_en) begin
                    read_value[port_io_pkg::EXTRST_BIT] = 1'b1;
                end
            end
        end
        if (!hit) begin
            read_value = port_io_pkg::UNMAPPED_VAL;
        end
    end

    // read data is held until the next read strobe
    always_comb begin
        rdata_d = rdata_q;
        if (cpu_rd) begin
            rdata_d = read_value;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= port_io_pkg::RESET_VAL;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign cpu_rdata = rdata_q;

endmodule : mcu_port_io_block

// file: rtl/port_io_pkg.sv
// shared constants for the port i/o block: addresses, bit masks, resets
package port_io_pkg;

    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int NUM_PORTS = 4;           // index 0..3 = port0/1/2/5
    localparam int PORT_W    = 8;

    typedef logic [7:0] byte_t;
    typedef logic [3:0][7:0] port_bytes_t;  // one byte per port

    // ------------------------------------------------------------------
    // register addresses in data memory (index 0 = port0 ... 3 = port5)
    // ------------------------------------------------------------------
    localparam port_bytes_t DIR_ADDR  = {8'hC5, 8'hC2, 8'hC1, 8'hB8};
    localparam port_bytes_t DATA_ADDR = {8'hD5, 8'hD2, 8'hD1, 8'hD0};
    localparam port_bytes_t PU_ADDR   = {8'hE5, 8'hE2, 8'hE1, 8'hE0};
    localparam byte_t       OD_ADDR   = 8'hE9;

    // ------------------------------------------------------------------
    // implemented bits and bits fixed at one
    // ------------------------------------------------------------------
    localparam port_bytes_t PIN_MASK   = {8'h10, 8'h3F, 8'h0F, 8'h01};
    localparam port_bytes_t DIR_MASK   = {8'h10, 8'h3F, 8'h0D, 8'h01};
    localparam port_bytes_t DIR_ONES   = {8'h00, 8'h00, 8'h02, 8'h00};
    localparam port_bytes_t LATCH_MASK = {8'h10, 8'h1F, 8'h0F, 8'h01};
    localparam port_bytes_t PU_MASK    = {8'h10, 8'h3F, 8'h0D, 8'h01};
    localparam port_bytes_t PU_ONES    = {8'h00, 8'h00, 8'h02, 8'h00};
    localparam byte_t       OD_MASK    = 8'h01;
    localparam byte_t       OD_ONES    = 8'h00;

    // pins with special behaviour
    localparam port_bytes_t INPUT_ONLY = {8'h00, 8'h00, 8'h02, 8'h00};
    localparam port_bytes_t OD_CAPABLE = {8'h00, 8'h00, 8'h01, 8'h00};
    localparam int          EXTRST_PORT = 1;
    localparam int          EXTRST_BIT  = 1;
    localparam int          OD_BIT      = 0;

    // ------------------------------------------------------------------
    // reset and default values
    // ------------------------------------------------------------------
    localparam byte_t RESET_VAL    = 8'h00;
    localparam byte_t UNMAPPED_VAL = 8'h00;  // write-only regs read this

endpackage : port_io_pkg

// file: rtl/port_reg.sv
// one 8-bit port control register with byte write and bit set/clear
`timescale 1ns/1ps
module port_reg #(
    parameter logic [7:0] IMPL = 8'hFF,
    parameter logic [7:0] ONES = 8'h00
) (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       sel,
    input  wire logic       wr,
    input  wire logic       bset,
    input  wire logic       bclr,
    input  wire logic [2:0] bit_sel,
    input  wire logic [7:0] wdata,
    output logic      [7:0] value
);

    logic [7:0] stored_q;
    logic [7:0] stored_d;
    logic [7:0] onehot;

    // next value; only implemented bits ever change
    always_comb begin
        onehot   = 8'(8'h01 << bit_sel);
        stored_d = stored_q;
        if (sel && wr) begin
            stored_d = wdata & IMPL;
        end else if (sel && bset) begin
            stored_d = (stored_q | onehot) & IMPL;
        end else if (sel && bclr) begin
            stored_d = stored_q & ~onehot & IMPL;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stored_q <= port_io_pkg::RESET_VAL;
        end else begin
            stored_q <= stored_d;
        end
    end

    // fixed-one bits cannot be written away
    assign value = stored_q | ONES;

endmodule : port_reg

// file: rtl/pin_driver.sv
// registered pad control for one port pin
`timescale 1ns/1ps
module pin_driver (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic exists,
    input  wire logic input_only,
    input  wire logic dir,
    input  wire logic latch,
    input  wire logic pu_en,
    input  wire logic od_en,
    output logic      out_q,
    output logic      oe_q,
    output logic      pu_q
);

    logic out_d;
    logic oe_d;
    logic pu_d;

    // open drain only sinks; push-pull drives the latch both ways
    always_comb begin
        out_d = 1'b0;
        oe_d  = 1'b0;
        if (exists && !input_only && dir) begin
            if (od_en) begin
                out_d = 1'b0;
                oe_d  = !latch;
            end else begin
                out_d = latch;
                oe_d  = 1'b1;
            end
        end
        // pull-up only acts while the pad is not driving
        pu_d = exists && !input_only && pu_en && !oe_d;
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= 1'b0;
            oe_q  <= 1'b0;
            pu_q  <= 1'b0;
        end else begin
            out_q <= out_d;
            oe_q  <= oe_d;
            pu_q  <= pu_d;
        end
    end

endmodule : pin_driver

// file: verification/pad_model.sv
// far-side model of one port: pins, outside drivers and pull resistors
`timescale 1ns/1ps
module pad_model #(
    parameter logic [7:0] RES = 8'h00
) (
    input  wire logic       mclk,
    input  wire logic [7:0] out,
    input  wire logic [7:0] oe,
    input  wire logic [7:0] pu,
    input  wire logic [7:0] ext,
    input  wire logic [7:0] en,
    output logic      [7:0] lvl
);
    logic [7:0] flt_q = 8'h55;

    // a pin nobody holds wanders, so a stale level never passes for real
    always @(posedge mclk) begin
        flt_q <= ~flt_q;
    end

    assign lvl = (oe & out) | (~oe & en & ext)
               | (~oe & ~en & (pu | RES | flt_q));
endmodule : pad_model

// file: verification/port_io_sva.sv
// concurrent checks on the port i/o block pins and read port
`timescale 1ns/1ps
module port_io_sva (
    input wire logic       mclk,
    input wire logic       rst_n,
    input wire logic [7:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic       cpu_wr,
    input wire logic       cpu_bit_set,
    input wire logic       cpu_bit_clr,
    input wire logic [2:0] cpu_bit_sel,
    input wire logic       cpu_rd,
    input wire logic [7:0] cpu_rdata,
    input wire logic       ext_reset_en,
    input wire logic [7:0] port0_in,
    input wire logic [7:0] port0_oe,
    input wire logic [7:0] port1_oe,
    input wire logic [7:0] port1_pu,
    input wire logic [7:0] port2_oe,
    input wire logic [7:0] port2_pu
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // a register change is seen on the pads only if nothing overwrites it
    sequence s_quiet;
        !cpu_wr && !cpu_bit_set && !cpu_bit_clr;
    endsequence
    sequence s_dir2_wr;
        cpu_wr && cpu_addr == 8'hC2 ##1 s_quiet;
    endsequence
    sequence s_dir2_clr;
        cpu_bit_clr && !cpu_wr && !cpu_bit_set && cpu_addr == 8'hC2
            && cpu_bit_sel == 3'h0 ##1 s_quiet;
    endsequence

    a_dir_drives_pad: assert property (
        s_dir2_wr |=> port2_oe[0] == $past(cpu_wdata[0], 2))
        else $error("direction write not seen on pad enable");
    a_bitclr_releases: assert property (
        s_dir2_clr |=> !port2_oe[0])
        else $error("bit clear did not release pad");
    a_pin11_inert: assert property (
        !port1_oe[1] && !port1_pu[1])
        else $error("input-only pin driven or pulled");
    a_absent_quiet: assert property (
        port0_oe[7:1] == 7'h00 && port1_oe[7:4] == 4'h0)
        else $error("absent pin driven");
    a_pull_not_drive: assert property (
        (port2_pu & port2_oe) == 8'h00)
        else $error("pull-up on a driven pin");
    a_wo_reads_zero: assert property (
        cpu_rd && cpu_addr == 8'hE9 |=> cpu_rdata == 8'h00)
        else $error("write-only register read nonzero");
    a_dir1_fixed: assert property (
        cpu_rd && cpu_addr == 8'hC1 |=> cpu_rdata[1] && !cpu_rdata[7:4])
        else $error("port1 direction fixed bits wrong");
    a_data_live: assert property (
        cpu_rd && cpu_addr == 8'hD0
            |=> cpu_rdata == {7'h00, $past(port0_in[0])})
        else $error("port0 data read not the pin level");
    a_extrst_one: assert property (
        cpu_rd && cpu_addr == 8'hD1 && ext_reset_en |=> cpu_rdata[1])
        else $error("reset pin data bit not one");
    a_rdata_holds: assert property (
        !cpu_rd |=> $stable(cpu_rdata))
        else $error("read data moved without a read");
endmodule : port_io_sva

bind mcu_port_io_block port_io_sva chk (.*);

// file: verification/testbench.sv
// self-checking bench for the port i/o block
`timescale 1ns/1ps
module testbench;
    logic mclk = 1'b0;
    logic rst_n, cpu_wr, cpu_bit_set, cpu_bit_clr, cpu_rd, ext_reset_en;
    logic rd_seen = 1'b0;
    logic od;
    logic [2:0] cpu_bit_sel;
    logic [7:0] cpu_addr, cpu_wdata, cpu_rdata;
    logic [7:0] port0_in, port0_out, port0_oe, port0_pu;
    logic [7:0] port1_in, port1_out, port1_oe, port1_pu;
    logic [7:0] port2_in, port2_out, port2_oe, port2_pu;
    logic [7:0] port5_in, port5_out, port5_oe, port5_pu;
    port_io_pkg::byte_t dir_m[4], lat_m[4], pu_m[4], ev[4], en[4], q[$];
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;

    mcu_port_io_block uut (.*);
    pad_model pm0 (.mclk(mclk), .out(port0_out), .oe(port0_oe),
        .pu(port0_pu), .ext(ev[0]), .en(en[0]), .lvl(port0_in));
    pad_model #(.RES(8'h01)) pm1 (.mclk(mclk), .out(port1_out),
        .oe(port1_oe), .pu(port1_pu), .ext(ev[1]), .en(en[1]),
        .lvl(port1_in));
    pad_model pm2 (.mclk(mclk), .out(port2_out), .oe(port2_oe),
        .pu(port2_pu), .ext(ev[2]), .en(en[2]), .lvl(port2_in));
    pad_model pm5 (.mclk(mclk), .out(port5_out), .oe(port5_oe),
        .pu(port5_pu), .ext(ev[3]), .en(en[3]), .lvl(port5_in));

    always #12.5 mclk = ~mclk;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic cmp(port_io_pkg::byte_t g, port_io_pkg::byte_t e);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, g, e);
        end
    endtask : cmp

    task automatic report_and_stop;
        $display("errors %0d, checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop

    // one-cycle strobe: 0 move, 1 bit set, 2 bit clear, 3 read
    task automatic acc(int k, port_io_pkg::byte_t a, port_io_pkg::byte_t d);
        @(posedge mclk);
        cpu_addr    <= a;
        cpu_wdata   <= d;
        cpu_bit_sel <= d[2:0];
        cpu_wr      <= (k == 0);
        cpu_bit_set <= (k == 1);
        cpu_bit_clr <= (k == 2);
        cpu_rd      <= (k == 3);
        @(posedge mclk);
        {cpu_wr, cpu_bit_set, cpu_bit_clr, cpu_rd} <= 4'h0;
    endtask : acc

    task automatic rd(port_io_pkg::byte_t a, port_io_pkg::byte_t e);
        q.push_back(e);
        acc(3, a, 8'h00);
    endtask : rd

    // r selects direction (0), data latch (1) or pull-up (2) of port i
    task automatic wr(int k, int r, int i, port_io_pkg::byte_t d);
        port_io_pkg::byte_t a, v;
        a = (r == 0) ? port_io_pkg::DIR_ADDR[i] : (r == 1) ?
            port_io_pkg::DATA_ADDR[i] : port_io_pkg::PU_ADDR[i];
        v = (r == 0) ? dir_m[i] : (r == 1) ? lat_m[i] : pu_m[i];
        acc(k, a, d);
        if (k == 0) v = d;
        else v[d[2:0]] = (k == 1);
        if (r == 0) dir_m[i] = v & port_io_pkg::DIR_MASK[i]
                               | port_io_pkg::DIR_ONES[i];
        else if (r == 1) lat_m[i] = v;
        else pu_m[i] = v & port_io_pkg::PU_MASK[i];
    endtask : wr

    // pin 1.0 drive state one edge after a register change
    task automatic pad(logic [1:0] e);
        @(posedge mclk);
        #1;
        cmp({6'h00, port1_oe[0], port1_oe[0] & port1_out[0]}, {6'h00, e});
    endtask : pad

    // level each pin should show, from the modelled registers
    function automatic port_io_pkg::byte_t pin_exp(int i);
        port_io_pkg::byte_t drv, pul, lv;
        drv = dir_m[i] & port_io_pkg::PIN_MASK[i]
            & ~port_io_pkg::INPUT_ONLY[i];
        if (i == 1 && od && lat_m[1][0]) drv[0] = 1'b0;
        pul = (pu_m[i] & ~drv) | ((i == 1) ? 8'h01 : 8'h00);
        lv = (drv & lat_m[i] & port_io_pkg::LATCH_MASK[i])
           | (~drv & en[i] & ev[i]) | (~drv & ~en[i] & pul);
        lv = lv & port_io_pkg::PIN_MASK[i];
        if (i == 1 && ext_reset_en) lv[1] = 1'b1;
        return lv;
    endfunction : pin_exp

    // compare each read answer with the oldest noted expectation
    always @(posedge mclk) begin
        if (rd_seen) cmp(cpu_rdata, q.pop_front());
        rd_seen <= cpu_rd;
    end

    // cut a hang short; the whole run needs well under a thousand cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_errors++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {cpu_wr, cpu_bit_set, cpu_bit_clr, cpu_rd, ext_reset_en} = 5'h00;
        {cpu_addr, cpu_wdata} = 16'h0000;
        cpu_bit_sel = 3'h0;
        rst_n = 1'b0;
        od = 1'b0;
        void'($urandom(21962));
        for (int i = 0; i < 4; i++) begin
            dir_m[i] = port_io_pkg::DIR_ONES[i];
            lat_m[i] = 8'h00;
            pu_m[i] = 8'h00;
            en[i] = 8'hFF;
            ev[i] = 8'($urandom);
        end
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(port_io_pkg::DIR_ADDR[i], dir_m[i]);
            rd(port_io_pkg::DATA_ADDR[i], pin_exp(i));
            rd(port_io_pkg::PU_ADDR[i], 8'h00);
        end
        rd(port_io_pkg::OD_ADDR, 8'h00);
        rd(8'h00, 8'h00);
        repeat (3) for (int i = 0; i < 4; i++) begin
            wr(0, 0, i, 8'($urandom));
            rd(port_io_pkg::DIR_ADDR[i], dir_m[i]);
            wr(2, 0, i, 8'($urandom % 8));
            wr(1, 0, i, 8'($urandom % 8));
            rd(port_io_pkg::DIR_ADDR[i], dir_m[i]);
            wr(0, 1, i, 8'($urandom));
            wr(1, 1, i, 8'($urandom % 8));
            rd(port_io_pkg::DATA_ADDR[i], pin_exp(i));
        end
        wr(0, 0, 2, 8'h01);
        wr(2, 0, 2, 8'h00);
        ext_reset_en <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(0, 0, i, 8'h00);
            wr(0, 2, i, 8'hFF);
            en[i] = 8'h00;
            rd(port_io_pkg::DATA_ADDR[i], pin_exp(i));
            rd(port_io_pkg::PU_ADDR[i], 8'h00);
        end
        en[1] = 8'hFE;
        wr(0, 2, 1, 8'h00);
        wr(0, 0, 1, 8'hFF);
        wr(0, 1, 1, 8'h01);
        acc(0, port_io_pkg::OD_ADDR, 8'h01);
        od = 1'b1;
        pad(2'h0);
        rd(port_io_pkg::DATA_ADDR[1], pin_exp(1));
        wr(0, 1, 1, 8'h00);
        pad(2'h2);
        rd(port_io_pkg::DATA_ADDR[1], pin_exp(1));
        wr(0, 1, 1, 8'h01);
        acc(0, port_io_pkg::OD_ADDR, 8'h00);
        od = 1'b0;
        pad(2'h3);
        wr(0, 0, 1, 8'h00);
        pad(2'h0);
        wr(0, 0, 1, 8'h01);
        pad(2'h3);
        repeat (3) @(posedge mclk);
        report_and_stop();
    end
endmodule : testbench
